//--- logic/cmsd_pkg.sv
// Shared constants and types for the core memory-space decoder
`default_nettype none
package cmsd_pkg;
  // Locally held special function register addresses
  localparam logic [7:0] SFR_SP = 8'h81;
  localparam logic [7:0] SFR_DPL = 8'h82;
  localparam logic [7:0] SFR_DPH = 8'h83;
  localparam logic [7:0] SFR_PROGRAM_STORE_CONTROL = 8'h8f;
  localparam logic [7:0] SFR_PSW = 8'hd0;
  localparam logic [7:0] SFR_ACC = 8'he0;
  localparam logic [7:0] SFR_AUXB = 8'hf0;
  // Reset values
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic [7:0] REG_RST = 8'h00;
  // Field positions
  localparam int PSW_RS_LO = 3;
  localparam int PSW_RS_HI = 4;
  localparam int PROGRAM_STORE_CONTROL_WEN = 0;
  localparam int DIR_SFR_BIT = 7;
  // Memory map figures
  localparam logic [7:0] BIT_BASE = 8'h20;
  localparam logic [15:0] PMEM_LAST = 16'h3dff;
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_NOP_ALT = 8'ha5;
  // Access kind, given by the instruction's operand type
  typedef enum logic [2:0] {
    CMSD_K_DIR = 3'h0,
    CMSD_K_IND = 3'h1,
    CMSD_K_REG = 3'h2,
    CMSD_K_BIT = 3'h3,
    CMSD_K_PUSH = 3'h4,
    CMSD_K_POP = 3'h5,
    CMSD_K_XWR = 3'h6
  } cmsd_kind_e;
  // Branch target forms
  typedef enum logic [1:0] {
    CMSD_B_REL = 2'h0,
    CMSD_B_ABS = 2'h1,
    CMSD_B_LONG = 2'h2
  } cmsd_br_e;
endpackage
`default_nettype wire

//--- logic/cmsd_ram_if.sv
// Port bundle between the decoder and its internal data RAM
`default_nettype none
interface cmsd_ram_if;
  logic re;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output re, output we, output addr, output wdata,
                input rdata);
  modport mem (input re, input we, input addr, input wdata,
               output rdata);
endinterface
`default_nettype wire

//--- logic/cmsd_ram.sv
// Internal data RAM, synchronous read, read-before-write
`default_nettype none
module cmsd_ram #(
  parameter int DEPTH = 256
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  cmsd_ram_if.mem bus
);
  typedef struct packed {
    logic [7:0] rdata;
  } cmsd_ram_s;
  cmsd_ram_s q_r;
  cmsd_ram_s q_nxt;
  logic [7:0] mem [DEPTH];

  // Read data is held until the next read
  always_comb begin
    q_nxt = q_r;
    if (bus.re) begin
      q_nxt.rdata = mem[bus.addr];
    end
  end

  // Contents are left unreset, as any RAM
  always_ff @(posedge clk_i) begin
    if (bus.we) begin
      mem[bus.addr] <= bus.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign bus.rdata = q_r.rdata;
endmodule
`default_nettype wire

//--- logic/cmsd_branch.sv
// Branch target former for relative, page and long forms
`default_nettype none
module cmsd_branch (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic valid_i,
  input wire cmsd_pkg::cmsd_br_e kind_i,
  input wire logic [15:0] next_pc_i,
  input wire logic [15:0] operand_i,
  output logic [15:0] target_o,
  output logic rsvd_o,
  output logic done_o
);
  typedef struct packed {
    logic [15:0] target;
    logic rsvd;
    logic done;
  } cmsd_br_s;
  cmsd_br_s q_r;
  cmsd_br_s q_nxt;
  logic [15:0] tgt;

  // Target per form; result is registered for timing
  always_comb begin
    q_nxt = q_r;
    tgt = next_pc_i;
    if (kind_i == cmsd_pkg::CMSD_B_REL) begin
      tgt = next_pc_i + {{8{operand_i[7]}}, operand_i[7:0]};
    end else if (kind_i == cmsd_pkg::CMSD_B_ABS) begin
      tgt = {next_pc_i[15:11], operand_i[10:0]};
    end else begin
      tgt = operand_i;
    end
    q_nxt.done = valid_i;
    if (valid_i) begin
      q_nxt.target = tgt;
      q_nxt.rsvd = tgt > cmsd_pkg::PMEM_LAST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign target_o = q_r.target;
  assign rsvd_o = q_r.rsvd;
  assign done_o = q_r.done;

  a_rel_target: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    valid_i && kind_i == cmsd_pkg::CMSD_B_REL |=>
    target_o == $past(next_pc_i) + {{8{$past(operand_i[7])}},
    $past(operand_i[7:0])})
    else $error("relative target wrong");
  a_page_target: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    valid_i && kind_i == cmsd_pkg::CMSD_B_ABS |=>
    target_o[15:11] == $past(next_pc_i[15:11]))
    else $error("page target left its page");
  a_rsvd_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    done_o |-> rsvd_o == (target_o > cmsd_pkg::PMEM_LAST))
    else $error("reserved flag wrong");
endmodule
`default_nettype wire

//--- logic/cmsd_core.sv
// Core memory-space decoder: RAM, banks, bits, stack and SFR routing
// Behaviour
// - Relative branch adds signed byte to address after the branch
// - Short absolute forms keep page bits, take 11 bits from operand
// - Long forms take the full 16-bit target anywhere in code
// - Opcode 0xA5 behaves exactly as a no-operation
// - Program store is 0x0000 to 0x3FFF, above 0x3DFF is reserved
// - Store control bit 0 sends external-data writes to program store
// - 256 bytes of RAM, lower half by direct or indirect modes
// - Above 0x7F indirect reaches upper RAM, direct reaches SFRs
// - RAM 0x00-0x1F holds four banks, status bits 3-4 pick one
// - Only the first two bank registers serve as indirect pointers
// - Bit addresses 0x00-0x7F map onto bytes 0x20-0x2F ascending
// - Bit or byte access is chosen by operand type, not address
// - Push writes one above the pointer, then increments it
// - Reset loads stack pointer with 0x07
// - Stack may sit anywhere in RAM, up to 256 bytes deep
// - Stack pointer lives at SFR address 0x81
// - Every direct access 0x80-0xFF goes to the SFR space
// - SFRs at addresses ending 0x0 or 0x8 are bit-addressable
`default_nettype none
module cmsd_core (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic REQ_VALID_I,
  input wire cmsd_pkg::cmsd_kind_e REQ_KIND_I,
  input wire logic REQ_WRITE_I,
  input wire logic [7:0] REQ_ADDR_I,
  input wire logic [7:0] REQ_WDATA_I,
  output logic REQ_READY_O,
  output logic RSP_VALID_O,
  output logic [7:0] RSP_DATA_O,
  output logic RSP_BIT_O,
  output logic PMEM_WE_O,
  output logic PMEM_RSVD_O,
  output logic XDATA_WE_O,
  output logic [15:0] XW_ADDR_O,
  output logic [7:0] XW_DATA_O,
  output logic SFR_EXT_RE_O,
  output logic SFR_EXT_WE_O,
  output logic [7:0] SFR_EXT_ADDR_O,
  output logic [7:0] SFR_EXT_WDATA_O,
  input wire logic [7:0] SFR_EXT_RDATA_I,
  input wire logic OP_VALID_I,
  input wire logic [7:0] OPCODE_I,
  output logic IS_NOP_O,
  input wire logic BR_VALID_I,
  input wire cmsd_pkg::cmsd_br_e BR_KIND_I,
  input wire logic [15:0] BR_NEXT_PC_I,
  input wire logic [15:0] BR_OPERAND_I,
  output logic [15:0] BR_TARGET_O,
  output logic BR_RSVD_O,
  output logic BR_DONE_O,
  output logic [7:0] STACK_PTR_O,
  output logic [1:0] BANK_SEL_O
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PTR = 4'b0010,
    ST_DATA = 4'b0100,
    ST_SFRX = 4'b1000
  } cmsd_st_e;

  typedef struct packed {
    cmsd_st_e st;
    cmsd_pkg::cmsd_kind_e kind;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] sp;
    logic [7:0] data_pointer_low;
    logic [7:0] data_pointer_high;
    logic [7:0] program_store_control;
    logic [7:0] processor_status_word;
    logic [7:0] acc;
    logic [7:0] auxb;
    logic ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_bit;
    logic pmem_we;
    logic pmem_rsvd;
    logic xdata_we;
    logic [15:0] xw_addr;
    logic [7:0] xw_data;
    logic sfr_re;
    logic sfr_we;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic no_operation;
  } cmsd_core_s;

  cmsd_core_s q_r;
  cmsd_core_s q_nxt;
  cmsd_ram_if ram_bus ();

  logic [1:0] bank;
  logic [7:0] la;
  logic l_hit;
  logic [7:0] l_val;
  logic lw_en;
  logic [7:0] lw_addr;
  logic [7:0] lw_val;
  logic [15:0] dptr;

  localparam int DIR_SFR_W = cmsd_pkg::DIR_SFR_BIT;
  localparam logic [7:0] BIT_BASE_W = cmsd_pkg::BIT_BASE;

  // Assertions below share this clock; all but a_sp_reset_val share this reset
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);

  // Bank register address inside the low 32 bytes
  function automatic logic [7:0] reg_addr(input logic [1:0] bk,
                                          input logic [2:0] idx);
    reg_addr = {3'h0, bk, idx};
  endfunction

  // Byte that holds a bit; SFR bits land on 0x?0 and 0x?8
  function automatic logic [7:0] bit_byte(input logic [7:0] ba);
    if (ba[DIR_SFR_W]) begin
      bit_byte = {ba[7:3], 3'h0};
    end else begin
      bit_byte = BIT_BASE_W + {4'h0, ba[6:3]};
    end
  endfunction

  // Replace one bit of a byte
  function automatic logic [7:0] bit_put(input logic [7:0] v,
                                         input logic [2:0] pos,
                                         input logic b);
    bit_put = v;
    bit_put[pos] = b;
  endfunction

  assign bank = q_r.processor_status_word[cmsd_pkg::PSW_RS_HI:cmsd_pkg::PSW_RS_LO];
  assign dptr = {q_r.data_pointer_high, q_r.data_pointer_low};
  // Local SFR address for this request, bit or byte by operand type
  assign la = (REQ_KIND_I == cmsd_pkg::CMSD_K_BIT) ?
              bit_byte(REQ_ADDR_I) : REQ_ADDR_I;

  // Locally held SFR read decode
  always_comb begin
    l_hit = 1'b1;
    l_val = 8'h00;
    if (la == cmsd_pkg::SFR_SP) begin
      l_val = q_r.sp;
    end else if (la == cmsd_pkg::SFR_DPL) begin
      l_val = q_r.data_pointer_low;
    end else if (la == cmsd_pkg::SFR_DPH) begin
      l_val = q_r.data_pointer_high;
    end else if (la == cmsd_pkg::SFR_PROGRAM_STORE_CONTROL) begin
      l_val = q_r.program_store_control;
    end else if (la == cmsd_pkg::SFR_PSW) begin
      l_val = q_r.processor_status_word;
    end else if (la == cmsd_pkg::SFR_ACC) begin
      l_val = q_r.acc;
    end else if (la == cmsd_pkg::SFR_AUXB) begin
      l_val = q_r.auxb;
    end else begin
      l_hit = 1'b0;
    end
  end

  // Main sequencer: one request at a time, answered once
  always_comb begin
    q_nxt = q_r;
    ram_bus.re = 1'b0;
    ram_bus.we = 1'b0;
    ram_bus.addr = 8'h00;
    ram_bus.wdata = 8'h00;
    lw_en = 1'b0;
    lw_addr = 8'h00;
    lw_val = 8'h00;
    q_nxt.rsp_valid = 1'b0;
    q_nxt.pmem_we = 1'b0;
    q_nxt.pmem_rsvd = 1'b0;
    q_nxt.xdata_we = 1'b0;
    q_nxt.sfr_re = 1'b0;
    q_nxt.sfr_we = 1'b0;
    q_nxt.no_operation = OP_VALID_I && (OPCODE_I == cmsd_pkg::OP_NOP ||
                OPCODE_I == cmsd_pkg::OP_NOP_ALT);
    case (q_r.st)
      ST_IDLE: begin
        if (REQ_VALID_I) begin
          q_nxt.kind = REQ_KIND_I;
          q_nxt.wr = REQ_WRITE_I;
          q_nxt.addr = REQ_ADDR_I;
          q_nxt.wdata = REQ_WDATA_I;
          case (REQ_KIND_I)
            cmsd_pkg::CMSD_K_REG: begin
              ram_bus.addr = reg_addr(bank, REQ_ADDR_I[2:0]);
              ram_bus.we = REQ_WRITE_I;
              ram_bus.re = !REQ_WRITE_I;
              ram_bus.wdata = REQ_WDATA_I;
              q_nxt.st = REQ_WRITE_I ? ST_IDLE : ST_DATA;
              q_nxt.rsp_valid = REQ_WRITE_I;
            end
            cmsd_pkg::CMSD_K_IND: begin
              // Pointer is R0 or R1 only
              ram_bus.addr = reg_addr(bank, {2'h0, REQ_ADDR_I[0]});
              ram_bus.re = 1'b1;
              q_nxt.st = ST_PTR;
            end
            cmsd_pkg::CMSD_K_DIR, cmsd_pkg::CMSD_K_BIT: begin
              if (!la[DIR_SFR_W]) begin
                // Lower RAM; bit writes need read-modify-write
                ram_bus.addr = la;
                if (REQ_WRITE_I &&
                    REQ_KIND_I == cmsd_pkg::CMSD_K_DIR) begin
                  ram_bus.we = 1'b1;
                  ram_bus.wdata = REQ_WDATA_I;
                  q_nxt.rsp_valid = 1'b1;
                end else begin
                  ram_bus.re = 1'b1;
                  q_nxt.st = ST_DATA;
                end
              end else if (l_hit) begin
                // Direct upper addresses never touch RAM
                lw_en = REQ_WRITE_I;
                lw_addr = la;
                lw_val = (REQ_KIND_I == cmsd_pkg::CMSD_K_BIT) ?
                         bit_put(l_val, REQ_ADDR_I[2:0], REQ_WDATA_I[0]) :
                         REQ_WDATA_I;
                q_nxt.rsp_valid = 1'b1;
                q_nxt.rsp_data = l_val;
                q_nxt.rsp_bit = l_val[REQ_ADDR_I[2:0]];
              end else begin
                // Other SFRs, reserved ones too, are owned outside
                q_nxt.sfr_addr = la;
                q_nxt.sfr_wdata = REQ_WDATA_I;
                if (REQ_WRITE_I &&
                    REQ_KIND_I == cmsd_pkg::CMSD_K_DIR) begin
                  q_nxt.sfr_we = 1'b1;
                  q_nxt.rsp_valid = 1'b1;
                end else begin
                  q_nxt.sfr_re = 1'b1;
                  q_nxt.st = ST_SFRX;
                end
              end
            end
            cmsd_pkg::CMSD_K_PUSH: begin
              // Pointer wraps: the full 256 bytes are usable
              ram_bus.we = 1'b1;
              ram_bus.addr = q_r.sp + 8'h01;
              ram_bus.wdata = REQ_WDATA_I;
              q_nxt.sp = q_r.sp + 8'h01;
              q_nxt.rsp_valid = 1'b1;
            end
            cmsd_pkg::CMSD_K_POP: begin
              ram_bus.re = 1'b1;
              ram_bus.addr = q_r.sp;
              q_nxt.sp = q_r.sp - 8'h01;
              q_nxt.st = ST_DATA;
            end
            cmsd_pkg::CMSD_K_XWR: begin
              q_nxt.xw_addr = dptr;
              q_nxt.xw_data = REQ_WDATA_I;
              if (q_r.program_store_control[cmsd_pkg::PROGRAM_STORE_CONTROL_WEN]) begin
                // Reserved code space is never written
                q_nxt.pmem_we = dptr <= cmsd_pkg::PMEM_LAST;
                q_nxt.pmem_rsvd = dptr > cmsd_pkg::PMEM_LAST;
              end else begin
                q_nxt.xdata_we = 1'b1;
              end
              q_nxt.rsp_valid = 1'b1;
            end
            default: begin
              q_nxt.rsp_valid = 1'b1;
            end
          endcase
        end
      end
      ST_PTR: begin
        // Pointer value picks RAM, upper half included
        ram_bus.addr = ram_bus.rdata;
        if (q_r.wr) begin
          ram_bus.we = 1'b1;
          ram_bus.wdata = q_r.wdata;
          q_nxt.rsp_valid = 1'b1;
          q_nxt.st = ST_IDLE;
        end else begin
          ram_bus.re = 1'b1;
          q_nxt.st = ST_DATA;
        end
      end
      ST_DATA: begin
        q_nxt.rsp_valid = 1'b1;
        q_nxt.rsp_data = ram_bus.rdata;
        q_nxt.rsp_bit = ram_bus.rdata[q_r.addr[2:0]];
        if (q_r.kind == cmsd_pkg::CMSD_K_BIT && q_r.wr) begin
          ram_bus.we = 1'b1;
          ram_bus.addr = bit_byte(q_r.addr);
          ram_bus.wdata = bit_put(ram_bus.rdata, q_r.addr[2:0],
                                  q_r.wdata[0]);
        end
        q_nxt.st = ST_IDLE;
      end
      ST_SFRX: begin
        // Outside data is valid while the read strobe is high
        q_nxt.rsp_valid = 1'b1;
        q_nxt.rsp_data = SFR_EXT_RDATA_I;
        q_nxt.rsp_bit = SFR_EXT_RDATA_I[q_r.addr[2:0]];
        if (q_r.kind == cmsd_pkg::CMSD_K_BIT && q_r.wr) begin
          q_nxt.sfr_we = 1'b1;
          q_nxt.sfr_wdata = bit_put(SFR_EXT_RDATA_I, q_r.addr[2:0],
                                    q_r.wdata[0]);
        end
        q_nxt.st = ST_IDLE;
      end
      default: begin
        q_nxt.st = ST_IDLE;
      end
    endcase
    // Local SFR write decode
    if (lw_en) begin
      if (lw_addr == cmsd_pkg::SFR_SP) begin
        q_nxt.sp = lw_val;
      end else if (lw_addr == cmsd_pkg::SFR_DPL) begin
        q_nxt.data_pointer_low = lw_val;
      end else if (lw_addr == cmsd_pkg::SFR_DPH) begin
        q_nxt.data_pointer_high = lw_val;
      end else if (lw_addr == cmsd_pkg::SFR_PROGRAM_STORE_CONTROL) begin
        q_nxt.program_store_control = lw_val;
      end else if (lw_addr == cmsd_pkg::SFR_PSW) begin
        q_nxt.processor_status_word = lw_val;
      end else if (lw_addr == cmsd_pkg::SFR_ACC) begin
        q_nxt.acc = lw_val;
      end else if (lw_addr == cmsd_pkg::SFR_AUXB) begin
        q_nxt.auxb = lw_val;
      end
    end
    q_nxt.ready = (q_nxt.st == ST_IDLE);
  end

  // State register with synchronous reset
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      q_r <= '0;
      q_r.st <= ST_IDLE;
      q_r.sp <= cmsd_pkg::SP_RST;
      q_r.processor_status_word <= cmsd_pkg::REG_RST;
      q_r.program_store_control <= cmsd_pkg::REG_RST;
      q_r.ready <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  cmsd_ram #(
    .DEPTH(256)
  ) u_ram (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .bus(ram_bus)
  );

  cmsd_branch u_branch (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .valid_i(BR_VALID_I),
    .kind_i(BR_KIND_I),
    .next_pc_i(BR_NEXT_PC_I),
    .operand_i(BR_OPERAND_I),
    .target_o(BR_TARGET_O),
    .rsvd_o(BR_RSVD_O),
    .done_o(BR_DONE_O)
  );

  // Outputs straight from state flops
  assign REQ_READY_O = q_r.ready;
  assign RSP_VALID_O = q_r.rsp_valid;
  assign RSP_DATA_O = q_r.rsp_data;
  assign RSP_BIT_O = q_r.rsp_bit;
  assign PMEM_WE_O = q_r.pmem_we;
  assign PMEM_RSVD_O = q_r.pmem_rsvd;
  assign XDATA_WE_O = q_r.xdata_we;
  assign XW_ADDR_O = q_r.xw_addr;
  assign XW_DATA_O = q_r.xw_data;
  assign SFR_EXT_RE_O = q_r.sfr_re;
  assign SFR_EXT_WE_O = q_r.sfr_we;
  assign SFR_EXT_ADDR_O = q_r.sfr_addr;
  assign SFR_EXT_WDATA_O = q_r.sfr_wdata;
  assign IS_NOP_O = q_r.no_operation;
  assign STACK_PTR_O = q_r.sp;
  assign BANK_SEL_O = bank;

  logic acc_go;
  assign acc_go = q_r.st == ST_IDLE && REQ_VALID_I;

  a_sp_reset_val: assert property (disable iff (1'b0)
    !RST_N_I |=> STACK_PTR_O == 8'h07)
    else $error("stack pointer not 0x07 after reset");
  a_push_order: assert property (acc_go &&
    REQ_KIND_I == cmsd_pkg::CMSD_K_PUSH |-> ram_bus.we &&
    ram_bus.addr == STACK_PTR_O + 8'h01 ##1
    STACK_PTR_O == $past(STACK_PTR_O) + 8'h01)
    else $error("push order wrong");
  a_pop_order: assert property (acc_go &&
    REQ_KIND_I == cmsd_pkg::CMSD_K_POP |-> !ram_bus.we &&
    ram_bus.addr == STACK_PTR_O ##1
    STACK_PTR_O == $past(STACK_PTR_O) - 8'h01 ##1 RSP_VALID_O)
    else $error("pop order wrong");
  a_bank_reg: assert property (acc_go &&
    REQ_KIND_I == cmsd_pkg::CMSD_K_REG |->
    ram_bus.addr == {3'h0, BANK_SEL_O, REQ_ADDR_I[2:0]})
    else $error("bank register address wrong");
  a_ptr_reg: assert property (acc_go &&
    REQ_KIND_I == cmsd_pkg::CMSD_K_IND |->
    ram_bus.addr[7:1] == {3'h0, BANK_SEL_O, 2'h0})
    else $error("pointer not R0 or R1");
  a_bit_map: assert property (acc_go &&
    REQ_KIND_I == cmsd_pkg::CMSD_K_BIT && !REQ_ADDR_I[7] |->
    ram_bus.addr == 8'h20 + {4'h0, REQ_ADDR_I[6:3]})
    else $error("bit address maps to wrong byte");
  a_direct_sfr: assert property (acc_go && REQ_ADDR_I[7] &&
    REQ_KIND_I == cmsd_pkg::CMSD_K_DIR |-> !ram_bus.re &&
    !ram_bus.we ##1 (q_r.st == ST_IDLE || q_r.st == ST_SFRX))
    else $error("direct upper access reached RAM");
  a_ind_upper: assert property (q_r.st == ST_PTR |->
    ram_bus.addr == ram_bus.rdata && !SFR_EXT_RE_O ##1
    !SFR_EXT_RE_O)
    else $error("indirect access left the RAM");
  a_store_route: assert property (acc_go &&
    REQ_KIND_I == cmsd_pkg::CMSD_K_XWR |=>
    (PMEM_WE_O || PMEM_RSVD_O) == $past(q_r.program_store_control[0]) &&
    XDATA_WE_O == !$past(q_r.program_store_control[0]))
    else $error("external write routed wrongly");
  a_nop_alias: assert property (OP_VALID_I && OPCODE_I == 8'ha5 |=>
    IS_NOP_O)
    else $error("0xA5 not a no-operation");
  a_rsp_bound: assert property (acc_go |-> ##[1:3] RSP_VALID_O)
    else $error("request not answered");

  c_push: cover property (acc_go && REQ_KIND_I == cmsd_pkg::CMSD_K_PUSH);
  c_ind_up: cover property (q_r.st == ST_PTR && ram_bus.rdata[7]);
  c_bit_wr: cover property (q_r.st == ST_DATA && q_r.wr &&
    q_r.kind == cmsd_pkg::CMSD_K_BIT);
  c_pmem_wr: cover property (PMEM_WE_O);
endmodule
`default_nettype wire

//--- dv/cmsd_sfr_model.sv
// Peripheral register bank behind the external special register strobes
`default_nettype none
module cmsd_sfr_model (
  input wire logic clk_i,
  input wire logic re_i,
  input wire logic we_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem_r [128];
  logic [7:0] last_r = 8'h00;
  // Data only while strobed, so a late sample never sees a stale byte
  always_comb rdata_o = re_i ? mem_r[addr_i[6:0]] : ~last_r;
  // Byte writes, including read-modify-write of single bits
  always @(posedge clk_i) begin
    if (re_i) last_r <= mem_r[addr_i[6:0]];
    if (we_i) mem_r[addr_i[6:0]] <= wdata_i;
  end
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the core memory-space decoder
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_SYS_I, RST_N_I, REQ_VALID_I, REQ_WRITE_I, OP_VALID_I;
  logic BR_VALID_I, REQ_READY_O, RSP_VALID_O, RSP_BIT_O, PMEM_WE_O;
  logic PMEM_RSVD_O, XDATA_WE_O, SFR_EXT_RE_O, SFR_EXT_WE_O, IS_NOP_O;
  logic BR_RSVD_O, BR_DONE_O;
  cmsd_pkg::cmsd_kind_e REQ_KIND_I;
  cmsd_pkg::cmsd_br_e BR_KIND_I;
  logic [7:0] REQ_ADDR_I, REQ_WDATA_I, SFR_EXT_RDATA_I, OPCODE_I;
  logic [7:0] RSP_DATA_O, SFR_EXT_ADDR_O, SFR_EXT_WDATA_O, STACK_PTR_O;
  logic [7:0] XW_DATA_O;
  logic [15:0] BR_NEXT_PC_I, BR_OPERAND_I, BR_TARGET_O, XW_ADDR_O;
  logic [1:0] BANK_SEL_O;
  int num_errors = 0, tests_run = 0, n_pm = 0, n_rs = 0, n_xd = 0;
  cmsd_core u_cmsd_core (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
    .REQ_VALID_I(REQ_VALID_I), .REQ_KIND_I(REQ_KIND_I),
    .REQ_WRITE_I(REQ_WRITE_I), .REQ_ADDR_I(REQ_ADDR_I),
    .REQ_WDATA_I(REQ_WDATA_I), .REQ_READY_O(REQ_READY_O),
    .RSP_VALID_O(RSP_VALID_O), .RSP_DATA_O(RSP_DATA_O),
    .RSP_BIT_O(RSP_BIT_O), .PMEM_WE_O(PMEM_WE_O),
    .PMEM_RSVD_O(PMEM_RSVD_O), .XDATA_WE_O(XDATA_WE_O),
    .XW_ADDR_O(XW_ADDR_O), .XW_DATA_O(XW_DATA_O),
    .SFR_EXT_RE_O(SFR_EXT_RE_O), .SFR_EXT_WE_O(SFR_EXT_WE_O),
    .SFR_EXT_ADDR_O(SFR_EXT_ADDR_O), .SFR_EXT_WDATA_O(SFR_EXT_WDATA_O),
    .SFR_EXT_RDATA_I(SFR_EXT_RDATA_I), .OP_VALID_I(OP_VALID_I),
    .OPCODE_I(OPCODE_I), .IS_NOP_O(IS_NOP_O), .BR_VALID_I(BR_VALID_I),
    .BR_KIND_I(BR_KIND_I), .BR_NEXT_PC_I(BR_NEXT_PC_I),
    .BR_OPERAND_I(BR_OPERAND_I), .BR_TARGET_O(BR_TARGET_O),
    .BR_RSVD_O(BR_RSVD_O), .BR_DONE_O(BR_DONE_O),
    .STACK_PTR_O(STACK_PTR_O), .BANK_SEL_O(BANK_SEL_O));
  cmsd_sfr_model u_cmsd_sfr_model (.clk_i(CLK_SYS_I), .re_i(SFR_EXT_RE_O),
    .we_i(SFR_EXT_WE_O), .addr_i(SFR_EXT_ADDR_O),
    .wdata_i(SFR_EXT_WDATA_O), .rdata_o(SFR_EXT_RDATA_I));
  // 50 MHz clock
  initial begin
    CLK_SYS_I = 0;
    forever #10 CLK_SYS_I = ~CLK_SYS_I;
  end
  // Strobe counters, sampled once per cycle after the edge settles
  always @(posedge CLK_SYS_I) begin
    #1;
    n_pm += (PMEM_WE_O === 1'b1);
    n_rs += (PMEM_RSVD_O === 1'b1);
    n_xd += (XDATA_WE_O === 1'b1);
  end
  task automatic check(input string nm, input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One request, held over its taking edge, then a bounded answer wait
  task automatic req(input cmsd_pkg::cmsd_kind_e k, input logic w,
                     input logic [7:0] a, d);
    int n;
    n = 0;
    @(negedge CLK_SYS_I);
    REQ_VALID_I = 1;
    REQ_KIND_I = k;
    REQ_WRITE_I = w;
    REQ_ADDR_I = a;
    REQ_WDATA_I = d;
    @(negedge CLK_SYS_I);
    REQ_VALID_I = 0;
    while (RSP_VALID_O !== 1'b1 && n < 20) begin
      @(posedge CLK_SYS_I);
      #1;
      n++;
    end
    if (n == 20) check("answer", 0, 1);
  endtask
  task automatic wr(input logic [7:0] a, d);
    req(cmsd_pkg::CMSD_K_DIR, 1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    req(cmsd_pkg::CMSD_K_DIR, 0, a, 0);
    check("direct", RSP_DATA_O, exp);
  endtask
  // Branch former: done one cycle after the request
  task automatic br(input cmsd_pkg::cmsd_br_e k, input logic [15:0] pc, op,
                    exp, input logic rs);
    @(negedge CLK_SYS_I);
    BR_VALID_I = 1;
    BR_KIND_I = k;
    BR_NEXT_PC_I = pc;
    BR_OPERAND_I = op;
    @(negedge CLK_SYS_I);
    BR_VALID_I = 0;
    check("br_done", BR_DONE_O, 1);
    check("target", BR_TARGET_O, exp);
    check("br_rsvd", BR_RSVD_O, rs);
  endtask
  task automatic t_stack;
    req(cmsd_pkg::CMSD_K_PUSH, 0, 0, 8'h5a);
    check("sp", STACK_PTR_O, 8'h08);
    rd(8'h08, 8'h5a);
    req(cmsd_pkg::CMSD_K_POP, 0, 0, 0);
    check("pop", RSP_DATA_O, 8'h5a);
    check("sp", STACK_PTR_O, 8'h07);
    wr(cmsd_pkg::SFR_SP, 8'hfe);
    rd(8'h81, 8'hfe);
    req(cmsd_pkg::CMSD_K_PUSH, 0, 0, 8'h11);
    check("sp", STACK_PTR_O, 8'hff);
  endtask
  task automatic t_ram;
    wr(cmsd_pkg::SFR_PSW, 8'h18);
    check("bank", BANK_SEL_O, 2'h3);
    req(cmsd_pkg::CMSD_K_REG, 1, 0, 8'h90);
    rd(8'h18, 8'h90);
    req(cmsd_pkg::CMSD_K_IND, 1, 0, 8'h3c);
    // Occupied port latch address, never a reserved hole
    wr(8'h90, 8'hc3);
    req(cmsd_pkg::CMSD_K_IND, 0, 0, 0);
    check("upper", RSP_DATA_O, 8'h3c);
    rd(8'h90, 8'hc3);
    wr(8'h40, 8'h77);
    req(cmsd_pkg::CMSD_K_REG, 1, 1, 8'h40);
    req(cmsd_pkg::CMSD_K_IND, 0, 1, 0);
    check("lower", RSP_DATA_O, 8'h77);
  endtask
  task automatic t_bits;
    wr(8'h22, 0);
    req(cmsd_pkg::CMSD_K_BIT, 1, 8'h13, 1);
    rd(8'h22, 8'h08);
    req(cmsd_pkg::CMSD_K_BIT, 0, 8'h13, 0);
    check("bit", RSP_BIT_O, 1);
    // RAM is unreset, so clear the byte before a single-bit write
    wr(8'h2f, 0);
    req(cmsd_pkg::CMSD_K_BIT, 1, 8'h7f, 1);
    rd(8'h2f, 8'h80);
    wr(8'h98, 0);
    req(cmsd_pkg::CMSD_K_BIT, 1, 8'h9b, 1);
    rd(8'h98, 8'h08);
  endtask
  task automatic t_store;
    wr(cmsd_pkg::SFR_DPH, 8'h3d);
    wr(cmsd_pkg::SFR_DPL, 8'hff);
    req(cmsd_pkg::CMSD_K_XWR, 0, 0, 8'haa);
    check("xdata", n_xd, 1);
    wr(cmsd_pkg::SFR_PROGRAM_STORE_CONTROL, 8'h01);
    req(cmsd_pkg::CMSD_K_XWR, 0, 0, 8'h55);
    check("pmem", n_pm, 1);
    check("xaddr", XW_ADDR_O, 16'h3dff);
    check("xdata_d", XW_DATA_O, 8'h55);
    wr(cmsd_pkg::SFR_DPH, 8'h3e);
    wr(cmsd_pkg::SFR_DPL, 8'h00);
    req(cmsd_pkg::CMSD_K_XWR, 0, 0, 8'h55);
    check("rsvd", n_rs, 1);
    check("pmem", n_pm, 1);
  endtask
  task automatic t_ops;
    logic [7:0] ops [2] = '{8'ha5, 8'h01};
    for (int i = 0; i < 2; i++) begin
      @(negedge CLK_SYS_I);
      OP_VALID_I = 1;
      OPCODE_I = ops[i];
      @(negedge CLK_SYS_I);
      OP_VALID_I = 0;
      check("nop", IS_NOP_O, i == 0);
    end
    br(cmsd_pkg::CMSD_B_REL, 16'h0102, 16'h00fe, 16'h0100, 0);
    br(cmsd_pkg::CMSD_B_ABS, 16'h0802, 16'h07ff, 16'h0fff, 0);
    br(cmsd_pkg::CMSD_B_LONG, 16'h0102, 16'h3e00, 16'h3e00, 1);
  endtask
  task automatic complete_run;
    $display("Checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard, far beyond the hundred or so cycles used
  initial begin
    #100us;
    num_errors++;
    complete_run();
  end
  initial begin
    {RST_N_I, REQ_VALID_I, REQ_WRITE_I, OP_VALID_I, BR_VALID_I} = 0;
    {REQ_ADDR_I, REQ_WDATA_I, OPCODE_I, BR_NEXT_PC_I, BR_OPERAND_I} = 0;
    REQ_KIND_I = cmsd_pkg::CMSD_K_DIR;
    BR_KIND_I = cmsd_pkg::CMSD_B_REL;
    repeat (16) @(posedge CLK_SYS_I);
    @(negedge CLK_SYS_I);
    RST_N_I = 1;
    check("sp_rst", STACK_PTR_O, cmsd_pkg::SP_RST);
    check("ready", REQ_READY_O, 1);
    t_stack();
    t_ram();
    t_bits();
    t_store();
    t_ops();
    complete_run();
  end
endmodule
`default_nettype wire
